// >>> hw/cmo_pkg.sv
// package for the message object control block
// shared by the control logic and the verification files
package cmo_pkg;
  localparam int          CMO_OBJ_COUNT   = 15;
  localparam logic [7:0]  CMO_SLOT_BYTES  = 8'h10;
  localparam logic [3:0]  CMO_CTRL0_OFS   = 4'h0;
  localparam logic [3:0]  CMO_CTRL1_OFS   = 4'h1;
  localparam logic [3:0]  CMO_SLOT_LAST   = 4'hF;
  localparam logic [7:0]  CMO_RESYNC_ADDR = 8'hFF;
  localparam logic [7:0]  CMO_RESYNC_DATA = 8'hFF;
  localparam logic [4:0]  CMO_RESYNC_LEN  = 5'h10;
  localparam logic [3:0]  CMO_BUF_OBJ     = 4'hF;
  localparam logic [1:0]  CMO_PAIR_CLR    = 2'h1;
  localparam logic [1:0]  CMO_PAIR_SET    = 2'h2;
  localparam logic [1:0]  CMO_PAIR_KEEP   = 2'h3;
  localparam logic [1:0]  CMO_READ_CLR    = 2'h1;
  localparam logic [1:0]  CMO_READ_SET    = 2'h2;
  localparam int          CMO_FIFO_DEPTH  = 16;
  localparam logic [14:0] CMO_FLAGS_RST   = 15'h0000;

  typedef struct packed {
    logic       valid;
    logic       tx_irq_enable;
    logic       rx_irq_enable;
    logic       irq_pending_flag;
    logic       remote_request_pending;
    logic       transmit_request;
    logic       overwrite_lost_flag;
    logic       fresh_data_flag;
  } cmo_flags_t;

  typedef struct packed {
    logic [3:0] obj;
    logic       remote;
  } cmo_txreq_t;

  typedef enum logic [1:0] {
    CMO_IDLE = 2'b00,
    CMO_BUSY = 2'b01,
    CMO_DONE = 2'b10
  } cmo_state_t;
endpackage

// >>> hw/cmo_fifo.sv
// fifo of transmit jobs
// same clock on both sides
`timescale 1ns/10ps
module cmo_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,     // system clock
  input  wire logic             rst_b,   // async reset, low
  input  wire logic             in_valid, // write strobe
  output      logic             in_ready, // not full
  input  wire logic [WIDTH-1:0] in_data, // write word
  output      logic             out_valid, // not empty
  input  wire logic             out_ready, // read strobe
  output      logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) mem[wr_ptr[AW-1:0]] <= in_data;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) wr_ptr <= wr_ptr + 1'b1;
      if (out_valid && out_ready) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // cmo_fifo

// >>> hw/cmo_ctrl.sv
// control and status bits of the 15 message objects
// host byte port, events from the can engine
// Operation
// - fifteen objects, sixteen byte slots
// - last slot byte belongs elsewhere
// - control bytes at offsets zero and one
// - read pairs: 01 clear, 10 set
// - write changes only addressed pairs
// - invalid objects never touched by engine
// - transmit success interrupts when enabled
// - receive success interrupts when enabled
// - enabled success sets pending, host clears
// - matching remote frame sets remote pending
// - remote answered only when unlocked, clears
// - remote pending alone starts nothing
// - data frame needs all five conditions
// - receive object request sends remote frame
// - remote frame sets request with pending
// - success clears request unless a same-cycle control 1 write sets fresh data or hits a transmit object with fresh data
// - overwrite sets lost; shared with lock
// - lock blocks transmission
// - object fifteen receive only, buffered
// - reception sets fresh data
// - lowest numbered object sent first
// - direction selects transmit or receive
`timescale 1ns/10ps
module cmo_ctrl
  import cmo_pkg::*;
#(
  parameter int NOBJ  = CMO_OBJ_COUNT,
  parameter int DEPTH = CMO_FIFO_DEPTH
) (
  input  wire logic            clk,          // 125 MHz system clock
  input  wire logic            rst_b,        // async reset, low
  input  wire logic            wr_en,        // host write strobe
  input  wire logic            rd_en,        // host read strobe
  input  wire logic [7:0]      addr,         // host byte address
  input  wire logic [7:0]      wdata,        // host write data
  output      logic [7:0]      rdata,        // host read data
  output      logic            rd_hit,       // address is a control byte
  output      logic            resync_done,  // sixteen FF bytes seen
  input  wire logic            init_hold,    // initialisation hold
  input  wire logic            global_irq_enable, // global irq enable
  input  wire logic [NOBJ-1:0] dir_tx,       // direction per object
  input  wire logic            rx_done,      // frame stored pulse
  input  wire logic            rx_remote,    // frame was remote
  input  wire logic [3:0]      rx_obj,       // matching object
  input  wire logic            tx_done,      // transmit success pulse
  input  wire logic [3:0]      tx_obj,       // object sent
  output      logic            tx_start,     // job offered to engine
  output      cmo_txreq_t      tx_job,       // object and frame kind
  input  wire logic            tx_take,      // engine accepts job
  output      logic            irq_req,      // any pending flag, if global irq enabled
  output      logic [NOBJ-1:0] pending_vec   // pending per object
);
  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic [3:0] obj_of(input logic [7:0] a);
    obj_of = a[7:4];
  endfunction
  function automatic logic is_ctrl(input logic [7:0] a);
    is_ctrl = (a[7:4] >= 4'h1) && (a[7:4] <= 4'(NOBJ))
            && ((a[3:0] == CMO_CTRL0_OFS) || (a[3:0] == CMO_CTRL1_OFS));
  endfunction
  function automatic logic pair_upd(input logic cur, input logic [1:0] p);
    case (p)
      CMO_PAIR_CLR: pair_upd = 1'b0;
      CMO_PAIR_SET: pair_upd = 1'b1;
      default:      pair_upd = cur;
    endcase
  endfunction
  function automatic logic [1:0] pair_rd(input logic f);
    pair_rd = f ? CMO_READ_SET : CMO_READ_CLR;
  endfunction

  cmo_flags_t       flg [NOBJ];
  logic [NOBJ-1:0]  lock;
  logic [NOBJ-1:0]  queued;
  logic [4:0]       ff_count;
  cmo_state_t       state;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [4:0]       fifo_out_data;
  logic [3:0]       pick;
  logic             pick_ok;
  logic             pick_remote;

  // ------------------------------------------------------------
  // serial resync counter
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff_count <= '0;
    end else if (wr_en && addr == CMO_RESYNC_ADDR) begin
      if (wdata != CMO_RESYNC_DATA) ff_count <= '0;
      else if (ff_count != CMO_RESYNC_LEN) ff_count <= ff_count + 5'h1;
    end
  end
  assign resync_done = (ff_count == CMO_RESYNC_LEN);

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata  <= 8'h00;
      rd_hit <= 1'b0;
    end else if (rd_en) begin
      rd_hit <= is_ctrl(addr);
      rdata  <= 8'h00;
      if (is_ctrl(addr)) begin
        if (addr[3:0] == CMO_CTRL0_OFS) begin
          rdata <= {pair_rd(flg[obj_of(addr)-1].valid),
                    pair_rd(flg[obj_of(addr)-1].tx_irq_enable),
                    pair_rd(flg[obj_of(addr)-1].rx_irq_enable),
                    pair_rd(flg[obj_of(addr)-1].irq_pending_flag)};
        end else begin
          rdata <= {pair_rd(flg[obj_of(addr)-1].remote_request_pending),
                    pair_rd(flg[obj_of(addr)-1].transmit_request),
                    pair_rd(dir_tx[obj_of(addr)-1] ? lock[obj_of(addr)-1]
                                                   : flg[obj_of(addr)-1].overwrite_lost_flag),
                    pair_rd(flg[obj_of(addr)-1].fresh_data_flag)};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // flags per object
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NOBJ; g++) begin : g_obj
      localparam logic [3:0] ID = 4'(g + 1);
      localparam logic       BUF = (ID == CMO_BUF_OBJ);
      wire logic w0  = wr_en && is_ctrl(addr) && obj_of(addr) == ID && addr[3:0] == CMO_CTRL0_OFS;
      wire logic w1  = wr_en && is_ctrl(addr) && obj_of(addr) == ID && addr[3:0] == CMO_CTRL1_OFS;
      wire logic txm = dir_tx[g] && !BUF;
      wire logic rxe = rx_done && rx_obj == ID && flg[g].valid;
      wire logic txe = tx_done && tx_obj == ID && flg[g].valid;
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          flg[g]  <= cmo_flags_t'(8'h00);
          lock[g] <= 1'b0;
        end else begin
          if (w0) begin
            flg[g].valid            <= pair_upd(flg[g].valid, wdata[7:6]);
            flg[g].tx_irq_enable    <= BUF ? 1'b0 : pair_upd(flg[g].tx_irq_enable, wdata[5:4]);
            flg[g].rx_irq_enable    <= pair_upd(flg[g].rx_irq_enable, wdata[3:2]);
            flg[g].irq_pending_flag <= pair_upd(flg[g].irq_pending_flag, wdata[1:0]);
          end
          if (w1) begin
            flg[g].remote_request_pending <= pair_upd(flg[g].remote_request_pending, wdata[7:6]);
            flg[g].transmit_request <= BUF ? 1'b0 : pair_upd(flg[g].transmit_request, wdata[5:4]);
            if (txm) lock[g] <= pair_upd(lock[g], wdata[3:2]);
            else flg[g].overwrite_lost_flag <= pair_upd(flg[g].overwrite_lost_flag, wdata[3:2]);
            flg[g].fresh_data_flag  <= pair_upd(flg[g].fresh_data_flag, wdata[1:0]);
          end
          // receive events override host writes in the same cycle; transmit success keeps a host control 1 fresh data write
          if (rxe) begin
            if (rx_remote && txm) begin
              flg[g].remote_request_pending <= 1'b1;
              flg[g].transmit_request       <= 1'b1;
            end else if (!rx_remote && !txm) begin
              flg[g].fresh_data_flag <= 1'b1;
              if (flg[g].fresh_data_flag) flg[g].overwrite_lost_flag <= 1'b1;
              if (flg[g].rx_irq_enable) flg[g].irq_pending_flag <= 1'b1;
            end
          end
          if (txe) begin
            if (!(w1 && wdata[1:0] == CMO_PAIR_SET) && !(txm && flg[g].fresh_data_flag && w1)) begin
              flg[g].transmit_request       <= 1'b0;
              flg[g].remote_request_pending <= 1'b0;
            end
            if (txm) flg[g].fresh_data_flag <= w1 ? pair_upd(flg[g].fresh_data_flag, wdata[1:0]) : 1'b0;
            if (flg[g].tx_irq_enable) flg[g].irq_pending_flag <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // transmit selection, lowest number first
  // ------------------------------------------------------------
  always_comb begin
    pick        = 4'h0;
    pick_ok     = 1'b0;
    pick_remote = 1'b0;
    for (int i = NOBJ - 1; i >= 0; i--) begin
      if (!init_hold && flg[i].valid && flg[i].transmit_request && !queued[i]
          && i != NOBJ - 1) begin
        if (dir_tx[i] && flg[i].fresh_data_flag && !lock[i]) begin
          pick        = 4'(i + 1);
          pick_ok     = 1'b1;
          pick_remote = 1'b0;
        end else if (!dir_tx[i]) begin
          pick        = 4'(i + 1);
          pick_ok     = 1'b1;
          pick_remote = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= CMO_IDLE;
      queued   <= '0;
    end else begin
      case (state)
        CMO_IDLE: if (pick_ok && fifo_in_ready) begin
          queued[pick-1] <= 1'b1;
          state          <= CMO_BUSY;
        end
        CMO_BUSY: state <= CMO_DONE;
        CMO_DONE: state <= CMO_IDLE;
        default:  state <= CMO_IDLE;
      endcase
      if (tx_done && tx_obj >= 4'h1 && tx_obj <= 4'(NOBJ)) queued[tx_obj-1] <= 1'b0;
    end
  end

  cmo_fifo #(.WIDTH(5), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (state == CMO_IDLE && pick_ok),
    .in_ready  (fifo_in_ready),
    .in_data   ({pick, pick_remote}),
    .out_valid (fifo_out_valid),
    .out_ready (tx_take),
    .out_data  (fifo_out_data)
  );

  assign tx_start = fifo_out_valid;
  assign tx_job   = cmo_txreq_t'(fifo_out_data);

  // ------------------------------------------------------------
  // interrupt summary
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NOBJ; i++) pending_vec[i] = flg[i].irq_pending_flag;
  end
  assign irq_req = global_irq_enable && (|pending_vec);
endmodule // cmo_ctrl

// >>> dv/cmo_ctrl_assertions.sv
// assertions on the message object control ports
// bound into every cmo_ctrl, one clock domain
`timescale 1ns/10ps
module cmo_ctrl_assertions
  import cmo_pkg::*;
#(
  parameter int NOBJ  = CMO_OBJ_COUNT,
  parameter int DEPTH = CMO_FIFO_DEPTH
) (
  input wire logic            clk,               // clock
  input wire logic            rst_b,             // reset, low
  input wire logic            wr_en,             // write strobe
  input wire logic            rd_en,             // read strobe
  input wire logic [7:0]      addr,              // address
  input wire logic [7:0]      wdata,             // write data
  input wire logic [7:0]      rdata,             // read data
  input wire logic            rd_hit,            // control hit
  input wire logic            resync_done,       // resync level
  input wire logic            global_irq_enable, // irq enable
  input wire logic            rx_done,           // rx event
  input wire logic            tx_done,           // tx event
  input wire logic            tx_start,          // job offered
  input wire cmo_txreq_t      tx_job,            // job word
  input wire logic            tx_take,           // job taken
  input wire logic            irq_req,           // irq out
  input wire logic [NOBJ-1:0] pending_vec        // pending flags
);
  logic [4:0] ff_run;
  wire        ctrl_addr = (addr[7:4] != 4'h0) && (addr[3:1] == 3'h0);
  wire        ff_wr     = wr_en && (addr == CMO_RESYNC_ADDR);

  // run of ff bytes written to the resync address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff_run <= 5'h00;
    end else if (ff_wr) begin
      ff_run <= (wdata != CMO_RESYNC_DATA) ? 5'h00 : (ff_run == CMO_RESYNC_LEN) ? ff_run : ff_run + 5'h01;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence rd_ctrl;
    rd_en && ctrl_addr;
  endsequence
  sequence rd_other;
    rd_en && !ctrl_addr;
  endsequence
  sequence host_clr;
    wr_en && ctrl_addr && !addr[0] && wdata[1:0] == CMO_PAIR_CLR && !tx_done && !rx_done;
  endsequence

  miss_reads_zero_a: assert property (rd_other |=> rdata == 8'h00 && !rd_hit)
    else $error("non-control read not zero");
  ctrl_hit_a: assert property (rd_ctrl |=> rd_hit)
    else $error("control byte not hit");
  pair_code_a: assert property (rd_hit |-> ^rdata[7:6] && ^rdata[5:4] && ^rdata[3:2] && ^rdata[1:0])
    else $error("read pair not 01 or 10");
  irq_map_a: assert property (irq_req == (global_irq_enable && |pending_vec))
    else $error("irq_req wrong");
  buf_rx_only_a: assert property (tx_start |-> tx_job.obj != CMO_BUF_OBJ)
    else $error("object fifteen queued");
  job_hold_a: assert property (tx_start && !tx_take |=> tx_start && $stable(tx_job))
    else $error("offered job changed");
  pend_clear_a: assert property (host_clr |=> !pending_vec[$past(addr[7:4]) - 4'h1])
    else $error("pending not cleared");
  resync_set_a: assert property (ff_run == CMO_RESYNC_LEN |-> ##[0:1] resync_done)
    else $error("resync not reported");
  resync_drop_a: assert property (ff_wr && wdata != CMO_RESYNC_DATA |=> !resync_done)
    else $error("resync kept after bad byte");
endmodule // cmo_ctrl_assertions

bind cmo_ctrl cmo_ctrl_assertions #(.NOBJ(NOBJ), .DEPTH(DEPTH)) u_chk (.clk, .rst_b, .wr_en, .rd_en, .addr,
  .wdata, .rdata, .rd_hit, .resync_done, .global_irq_enable, .rx_done, .tx_done, .tx_start, .tx_job,
  .tx_take, .irq_req, .pending_vec);

// >>> dv/cmo_engine_model.sv
// can engine model: takes jobs, reports success
// one job in flight; slow stalls the take
`timescale 1ns/10ps
module cmo_engine_model
  import cmo_pkg::*;
(
  input  wire logic       clk,      // clock
  input  wire logic       tx_start, // job offered
  input  wire cmo_txreq_t tx_job,   // job word
  input  wire logic       slow,     // stall takes
  output      logic       tx_take,  // accept pulse
  output      logic       tx_done,  // success pulse
  output      logic [3:0] tx_obj    // object sent
);
  initial begin
    tx_take = 1'b0;
    tx_done = 1'b0;
    tx_obj  = 4'h0;
    forever begin
      @(posedge clk);
      if (tx_start) begin
        if (slow) repeat (6) @(posedge clk);
        #1 tx_take = 1'b1;
        tx_obj = tx_job.obj;
        @(posedge clk);
        #1 tx_take = 1'b0;
        repeat (4) @(posedge clk);
        #1 tx_done = 1'b1;
        @(posedge clk);
        #1 tx_done = 1'b0;
        tx_obj = ~tx_obj; // no stale object after the pulse
      end
    end
  end
endmodule // cmo_engine_model

// >>> dv/test_can_message_object_control.sv
// testbench for the message object control block
// host tasks drive bytes, engine model answers jobs
`timescale 1ns/10ps
module test_can_message_object_control;
  import cmo_pkg::*;
  logic        clk, rst_b, wr_en, rd_en, init_hold, global_irq_enable, slow;
  logic        rx_done, rx_remote, tx_done, tx_start, tx_take, irq_req, rd_hit, resync_done, rd_seen;
  logic [7:0]  addr, wdata, rdata, v;
  logic [3:0]  rx_obj, tx_obj;
  logic [14:0] dir_tx, pending_vec;
  cmo_txreq_t  tx_job;
  logic [8:0]  rd_q[$];
  cmo_txreq_t  job_q[$];
  logic [7:0]  mdl[1:14][0:1];
  int          fail_count, n_compared, cycles, o, b;
  integer      seed;

  cmo_ctrl uut (.clk, .rst_b, .wr_en, .rd_en, .addr, .wdata, .rdata, .rd_hit, .resync_done, .init_hold,
    .global_irq_enable, .dir_tx, .rx_done, .rx_remote, .rx_obj, .tx_done, .tx_obj, .tx_start, .tx_job,
    .tx_take, .irq_req, .pending_vec);
  cmo_engine_model engine (.clk, .tx_start, .tx_job, .slow, .tx_take, .tx_done, .tx_obj);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr_en = 1'b0;
    wdata = ~d;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    rd_q.push_back({h, e});
    rd_en = 1'b1;
    addr = a;
    @(posedge clk);
    #1 rd_en = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic ev(input logic rem, input logic [3:0] ob);
    rx_remote = rem;
    rx_obj = ob;
    rx_done = 1'b1;
    @(posedge clk);
    #1 rx_done = 1'b0;
    rx_obj = ~ob;
    @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // read results and offered jobs against the notes
  always @(posedge clk) begin
    if (rd_seen) chk("rdata", rd_q.pop_front(), {rd_hit, rdata});
    rd_seen <= rd_en;
    if (tx_start && tx_take) chk("tx_job", job_q.size() ? 9'(job_q.pop_front()) : 9'h1ff, 9'(tx_job));
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    {wr_en, rd_en, rx_done, rx_remote, slow, rd_seen} = '0;
    {addr, wdata, rx_obj, fail_count, n_compared, cycles} = '0;
    seed = 32'h00d6;
    dir_tx = 15'h0016;
    init_hold = 1'b1;
    global_irq_enable = 1'b1;
    rst_b = 1'b0;
    for (o = 1; o < 15; o++) for (b = 0; b < 2; b++) mdl[o][b] = 8'h55;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    @(posedge clk);
    #1;
    repeat (15) wr(8'hFF, 8'hFF);
    chk("resync_done", 9'h000, 9'(resync_done));
    wr(8'hFF, 8'hFF);
    chk("resync_done", 9'h001, 9'(resync_done));
    wr(8'hFF, 8'h00);
    chk("resync_done", 9'h000, 9'(resync_done));
    for (int i = 0; i < 40; i++) begin
      o = 1 + ($unsigned($random(seed)) % 14);
      b = $random(seed) & 1;
      v = 8'($random(seed));
      for (int p = 0; p < 8; p += 2) begin
        if (v[p+:2] == 2'b00) v[p+:2] = CMO_PAIR_KEEP;
        if (v[p+:2] == CMO_PAIR_SET) mdl[o][b][p+:2] = CMO_READ_SET;
        if (v[p+:2] == CMO_PAIR_CLR) mdl[o][b][p+:2] = CMO_READ_CLR;
      end
      wr(8'(o * 16 + b), v);
      rd(8'(o * 16 + b), mdl[o][b], 1'b1);
    end
    for (o = 1; o < 15; o++) for (b = 0; b < 2; b++) wr(8'(o * 16 + b), 8'h55);
    for (b = 0; b < 2; b++) wr(8'(240 + b), 8'hEF);
    for (b = 0; b < 2; b++) rd(8'(240 + b), 8'h55, 1'b1);
    rd(8'h1F, 8'h00, 1'b0);
    rd(8'h12, 8'h00, 1'b0);
    wr(8'h50, 8'hAF);
    wr(8'h51, 8'h66);
    wr(8'h20, 8'hAF);
    wr(8'h21, 8'h66);
    job_q.push_back(5'h04);
    job_q.push_back(5'h0A);
    slow = 1'b1;
    init_hold = 1'b0;
    for (int k = 0; k < 300 && pending_vec !== 15'h0012; k++) @(posedge clk);
    #1 chk("irq_req", 9'h001, 9'(irq_req));
    chk("pending_vec", 9'h012, 9'(pending_vec));
    rd(8'h51, 8'h55, 1'b1);
    rd(8'h50, 8'hA6, 1'b1);
    wr(8'h50, 8'hFD);
    wr(8'h20, 8'hFD);
    rd(8'h50, 8'hA5, 1'b1);
    chk("irq_req", 9'h000, 9'(irq_req));
    slow = 1'b0;
    wr(8'h30, 8'hBF);
    wr(8'h31, 8'hFB);
    ev(1'b1, 4'h3);
    rd(8'h31, 8'hA9, 1'b1);
    job_q.push_back(5'h06);
    wr(8'h31, 8'hF6);
    for (int k = 0; k < 300 && !(tx_done && tx_obj == 4'h3); k++) @(posedge clk);
    #1 rd(8'h31, 8'h55, 1'b1);
    wr(8'h31, 8'hBF);
    rd(8'h31, 8'h95, 1'b1);
    wr(8'h31, 8'h7F);
    wr(8'h40, 8'hBB);
    ev(1'b0, 4'h4);
    ev(1'b0, 4'h4);
    rd(8'h41, 8'h5A, 1'b1);
    rd(8'h40, 8'h9A, 1'b1);
    chk("irq_req", 9'h001, 9'(irq_req));
    chk("pending_vec", 9'h008, 9'(pending_vec));
    ev(1'b0, 4'h6);
    rd(8'h61, 8'h55, 1'b1);
    job_q.push_back(5'h09);
    wr(8'h41, 8'hEF);
    for (int k = 0; k < 300 && !(tx_done && tx_obj == 4'h4); k++) @(posedge clk);
    #1 chk("job_q", 9'h000, 9'(job_q.size()));
    conclude();
  end
endmodule // test_can_message_object_control
